// *** design/bus_ctl_pkg.sv ***
// Shared constants and carriers for the two-wire bus control/status block
`default_nettype none
package bus_ctl_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'hC0;
	localparam logic [3:0] CTRL_PAGE   = 4'h0;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] WRITE_MASK  = 8'h33;
	localparam logic [7:0] FULL_MASK   = 8'hFF;

	// ----------------------------------------
	// Field positions, bit 7 down
	// ----------------------------------------
	localparam int BIT_MASTER  = 7;
	localparam int BIT_TRANSMIT = 6;
	localparam int BIT_BEGIN   = 5;
	localparam int BIT_HALT    = 4;
	localparam int BIT_ACK_REQUEST = 3;
	localparam int BIT_ARB_LOST    = 2;
	localparam int BIT_ACK     = 1;
	localparam int BIT_PENDING = 0;

	// One-cycle pulses and levels reported by the bit engine
	typedef struct packed {
		logic start_generated;
		logic stop_generated;
		logic start_detected;
		logic rstart_detected;
		logic start_addr_rx;
		logic stop_detected;
		logic addressed;
		logic byte_sent;
		logic byte_received;
		logic ack_cycle_done;
		logic ack_sampled;
		logic ack_value;
		logic data_write;
		logic frame_start;
	} bus_event_t;

	// Sensed line levels and what the engine is driving
	typedef struct packed {
		logic sda_in;
		logic scl_in;
		logic sda_drive_one;
		logic ack_phase;
		logic gen_stop_rstart;
	} line_sense_t;
endpackage
`default_nettype wire

// *** design/arb_lost_detect.sv ***
// Arbitration loss detector for the two-wire bus control block
`default_nettype none
module arb_lost_detect (
	input  wire logic                      i_clock,
	input  wire logic                      i_reset,
	input  wire bus_ctl_pkg::line_sense_t  i_line,
	input  wire logic                      i_rstart_detected,
	input  wire logic                      i_stop_detected,
	input  wire logic                      i_master,
	input  wire logic                      i_begin,
	output var  logic                      o_lost
);
	logic line_loss;
	logic line_loss_ff;

	// ----------------------------------------
	// Loss conditions
	// ----------------------------------------
	// Line conflicts are levels; only their onset counts as one loss
	always_comb begin
		line_loss = (i_line.sda_drive_one & ~i_line.sda_in & ~i_line.ack_phase)
			| (i_line.gen_stop_rstart & ~i_line.scl_in);
	end

	// Previous level for onset detection
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			line_loss_ff <= 1'b0;
		end else begin
			line_loss_ff <= line_loss;
		end
	end

	// Registered loss pulse, one cycle after its cause
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_lost <= 1'b0;
		end else begin
			o_lost <= (line_loss & ~line_loss_ff)
				| (i_rstart_detected & i_master & ~i_begin)
				| (i_stop_detected & i_master);
		end
	end
endmodule
`default_nettype wire

// *** design/bus_control_block.sv ***
// Control and status register of the two-wire bus interface
`default_nettype none
module bus_control_block #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                      i_clock,
	input  wire logic                      i_reset,
	input  wire logic [ADDR_WIDTH-1:0]     i_addr,
	input  wire logic [3:0]                i_page,
	input  wire logic [7:0]                i_wdata,
	input  wire logic                      i_write,
	input  wire logic                      i_read,
	input  wire logic                      i_bit_write,
	input  wire logic [2:0]                i_bit_index,
	input  wire logic                      i_bit_value,
	input  wire logic                      i_auto_ack_enable,
	input  wire bus_ctl_pkg::bus_event_t   i_evt,
	input  wire bus_ctl_pkg::line_sense_t  i_line,
	output var  logic [7:0]                o_rdata,
	output var  logic                      o_master,
	output var  logic                      o_transmit,
	output var  logic                      o_start_request,
	output var  logic                      o_stop_request,
	output var  logic                      o_ack_send,
	output var  logic                      o_scl_hold,
	output var  logic                      o_irq
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (ADDR_WIDTH < 8) begin : g_bad_width
		$error("ADDR_WIDTH must be at least 8");
	end

	logic       master_ff;
	logic       transmit_ff;
	logic       begin_ff;
	logic       halt_ff;
	logic       ack_request_ff;
	logic       arb_lost_ff;
	logic       ack_ff;
	logic       pending_ff;
	logic       ack_written_ff;
	logic       data_written_ff;
	logic       nxt_pending;
	logic       hit;
	logic [7:0] wmask;
	logic [7:0] wval;
	logic [7:0] reg_value;
	logic       lost;
	logic       pending_clear;
	logic       begin_drop;
	logic       halt_drop;

	// Merge byte and single-bit writes into mask and value
	function automatic logic [7:0] bit_onehot(input logic [2:0] idx);
		bit_onehot = 8'h01 << idx;
	endfunction

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	// Read-only bits drop out through the write mask
	always_comb begin
		hit = (i_addr == ADDR_WIDTH'(bus_ctl_pkg::CTRL_OFFSET))
			& (i_page == bus_ctl_pkg::CTRL_PAGE);
		wmask = 8'h00;
		wval  = i_wdata;
		if (hit & i_write) begin
			wmask = bus_ctl_pkg::FULL_MASK & bus_ctl_pkg::WRITE_MASK;
		end else if (hit & i_bit_write) begin
			wmask = bit_onehot(i_bit_index) & bus_ctl_pkg::WRITE_MASK;
			wval  = {8{i_bit_value}};
		end
		begin_drop = wmask[bus_ctl_pkg::BIT_BEGIN] & ~wval[bus_ctl_pkg::BIT_BEGIN];
		halt_drop  = wmask[bus_ctl_pkg::BIT_HALT] & ~wval[bus_ctl_pkg::BIT_HALT];
	end

	// Current register image, bit 7 down
	always_comb begin
		reg_value = {master_ff, transmit_ff, begin_ff, halt_ff,
			ack_request_ff, arb_lost_ff, ack_ff, pending_ff};
	end

	// ----------------------------------------
	// Arbitration loss
	// ----------------------------------------
	arb_lost_detect u_arb (
		.i_clock           (i_clock),
		.i_reset           (i_reset),
		.i_line            (i_line),
		.i_rstart_detected (i_evt.rstart_detected),
		.i_stop_detected   (i_evt.stop_detected),
		.i_master          (master_ff),
		.i_begin           (begin_ff),
		.o_lost            (lost)
	);

	// ----------------------------------------
	// Service pending
	// ----------------------------------------
	// Hardware sets beat a same-cycle software clear
	always_comb begin
		nxt_pending = pending_ff;
		if (wmask[bus_ctl_pkg::BIT_PENDING]) begin
			nxt_pending = wval[bus_ctl_pkg::BIT_PENDING];
		end
		if (i_evt.start_generated | lost | i_evt.byte_sent | i_evt.byte_received
			| i_evt.start_addr_rx | i_evt.stop_detected) begin
			nxt_pending = 1'b1;
		end
		pending_clear = pending_ff & ~nxt_pending;
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			pending_ff <= 1'b0;
		end else begin
			pending_ff <= nxt_pending;
		end
	end

	// Stall and interrupt track the flag with no extra lag
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_scl_hold <= 1'b0;
			o_irq      <= 1'b0;
		end else begin
			o_scl_hold <= nxt_pending;
			o_irq      <= nxt_pending;
		end
	end

	// Cleared only with the pending flag; a fresh loss still lands
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			arb_lost_ff <= 1'b0;
		end else if (lost) begin
			arb_lost_ff <= 1'b1;
		end else if (pending_clear) begin
			arb_lost_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Role and direction
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			master_ff <= 1'b0;
		end else if (lost | i_evt.stop_generated) begin
			master_ff <= 1'b0;
		end else if (i_evt.start_generated) begin
			master_ff <= 1'b1;
		end
	end

	// Remembers a data write ahead of the next frame
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			data_written_ff <= 1'b0;
		end else if (i_evt.frame_start) begin
			data_written_ff <= 1'b0; // Same-cycle write is used by this frame
		end else if (i_evt.data_write) begin
			data_written_ff <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			transmit_ff <= 1'b0;
		end else if (i_evt.start_generated) begin
			transmit_ff <= 1'b1;
		end else if (i_evt.start_detected | lost) begin
			transmit_ff <= 1'b0;
		end else if (i_evt.frame_start) begin
			transmit_ff <= data_written_ff | i_evt.data_write;
		end
	end

	// ----------------------------------------
	// Begin and halt
	// ----------------------------------------
	// Never cleared by hardware, so it keeps requesting until software drops it
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			begin_ff <= 1'b0;
		end else if (i_evt.start_addr_rx) begin
			begin_ff <= 1'b1;
		end else if (wmask[bus_ctl_pkg::BIT_BEGIN]) begin
			begin_ff <= wval[bus_ctl_pkg::BIT_BEGIN];
		end
	end

	// A halt write counts as controller if begin is written to 1 in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			halt_ff <= 1'b0;
		end else if ((i_evt.stop_detected & (i_evt.addressed | master_ff))) begin
			halt_ff <= 1'b1;
		end else if (i_evt.stop_generated) begin
			halt_ff <= 1'b0;
		end else if (wmask[bus_ctl_pkg::BIT_HALT]) begin
			halt_ff <= wval[bus_ctl_pkg::BIT_HALT]
				& (master_ff | (wmask[bus_ctl_pkg::BIT_BEGIN]
				& wval[bus_ctl_pkg::BIT_BEGIN]));
		end
	end

	// Requests wait out a stall; a same-cycle write of 0 cancels them at once
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_start_request <= 1'b0;
			o_stop_request  <= 1'b0;
		end else begin
			o_start_request <= begin_ff & ~begin_drop & ~nxt_pending;
			o_stop_request  <= halt_ff & ~halt_drop & master_ff & ~nxt_pending;
		end
	end

	// ----------------------------------------
	// Acknowledge
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_request_ff <= 1'b0;
		end else if (i_evt.byte_received & ~i_auto_ack_enable) begin
			ack_request_ff <= 1'b1;
		end else if (i_evt.ack_cycle_done) begin
			ack_request_ff <= 1'b0;
		end
	end

	// Incoming ack sample beats a software write in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_ff <= 1'b0;
		end else if (i_evt.ack_sampled) begin
			ack_ff <= ~i_evt.ack_value;
		end else if (wmask[bus_ctl_pkg::BIT_ACK]) begin
			ack_ff <= wval[bus_ctl_pkg::BIT_ACK];
		end
	end

	// Tracks whether software chose an ack since the last service
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_written_ff <= 1'b0;
		end else if (wmask[bus_ctl_pkg::BIT_ACK]) begin
			ack_written_ff <= 1'b1;
		end else if (pending_clear) begin
			ack_written_ff <= 1'b0;
		end
	end

	// Without a software choice the byte is refused unless auto-ack is enabled
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_ack_send <= 1'b0;
		end else begin
			o_ack_send <= ack_ff & (i_auto_ack_enable | ack_written_ff);
		end
	end

	// ----------------------------------------
	// Status outputs and read data
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_master   <= 1'b0;
			o_transmit <= 1'b0;
		end else begin
			o_master   <= master_ff;
			o_transmit <= transmit_ff;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_rdata <= bus_ctl_pkg::CTRL_RESET;
		end else if (i_read & hit) begin
			o_rdata <= reg_value;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	property p_reset_zero;
		$fell(i_reset) |-> (reg_value == bus_ctl_pkg::CTRL_RESET);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

	property p_master_set;
		i_evt.start_generated & ~lost & ~i_evt.stop_generated |=> master_ff ##1 o_master;
	endproperty
	a_master_set: assert property (p_master_set) else $error("role not set on START");

	property p_begin_set;
		i_evt.start_addr_rx |=> begin_ff;
	endproperty
	a_begin_set: assert property (p_begin_set) else $error("begin flag not set");

	property p_halt_clear;
		i_evt.stop_generated & ~i_evt.stop_detected |=> ~halt_ff;
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt flag not cleared");

	property p_ack_request;
		i_evt.byte_received & ~i_auto_ack_enable |=> ack_request_ff;
	endproperty
	a_ack_request: assert property (p_ack_request) else $error("ack request not set");

	property p_arb_clear;
		pending_ff ##1 ~pending_ff & ~$past(lost, 1) |-> ~arb_lost_ff;
	endproperty
	a_arb_clear: assert property (p_arb_clear) else $error("arbitration flag survived");

	property p_ack_capture;
		i_evt.ack_sampled |=> (ack_ff == ~$past(i_evt.ack_value));
	endproperty
	a_ack_capture: assert property (p_ack_capture) else $error("ack sample wrong");

	property p_pending_set;
		i_evt.byte_sent | i_evt.byte_received | i_evt.stop_detected
			|=> pending_ff & o_irq & o_scl_hold;
	endproperty
	a_pending_set: assert property (p_pending_set) else $error("pending not raised");

	property p_stall;
		pending_ff |-> o_scl_hold & o_irq & ~o_start_request & ~o_stop_request;
	endproperty
	a_stall: assert property (p_stall) else $error("bus not stalled");

	property p_start_req;
		begin_ff & ~begin_drop & ~nxt_pending |=> o_start_request;
	endproperty
	a_start_req: assert property (p_start_req) else $error("start not requested");
endmodule
`default_nettype wire

// *** dv/bus_engine_model.sv ***
// Far-side bit engine and line model for the bus control bench
`default_nettype none
module bus_engine_model (
	input  wire logic                      i_clock,
	input  wire logic                      i_reset,
	input  wire logic                      i_start_request,
	input  wire logic                      i_scl_hold,
	input  wire logic                      i_slow,
	input  wire logic                      i_conflict,
	input  wire logic [13:0]               i_fire,
	output var  bus_ctl_pkg::bus_event_t   o_evt,
	output var  bus_ctl_pkg::line_sense_t  o_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       req_ff;
	logic [2:0] wait_ff;

	// ----------------------------------------
	// Start generation
	// ----------------------------------------
	// One start per request rise; a rise seen while the clock line is held low gives none
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			req_ff  <= 1'b0;
			wait_ff <= 3'h0;
		end else begin
			req_ff <= i_start_request;
			if (i_start_request && !req_ff && !i_scl_hold) begin
				wait_ff <= i_slow ? 3'h5 : 3'h1;
			end else if (wait_ff != 3'h0) begin
				wait_ff <= wait_ff - 3'h1;
			end
		end
	end

	// Bench events relayed a cycle late; lines idle high by pull-up
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_evt  <= '0;
			o_line <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		end else begin
			o_evt  <= bus_ctl_pkg::bus_event_t'(i_fire | {wait_ff == 3'h1, 13'h0000});
			o_line <= '{!i_conflict, !i_scl_hold, i_conflict, 1'b0, 1'b0};
		end
	end
endmodule
`default_nettype wire

// *** dv/bus_control_block_test.sv ***
// Self-checking bench for the bus control/status register block
`default_nettype none
module bus_control_block_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0]  pre;
		logic [13:0] ev;
		logic [7:0]  exp;
	} row_t;
	logic                     i_clock;
	logic                     i_reset;
	logic                     write, read, bit_write, bit_value, slow, conflict;
	logic [7:0]               addr, wdata, rdata, d;
	logic [3:0]               page;
	logic [2:0]               bit_index;
	logic [13:0]              fire;
	logic                     master, transmit, start_req, stop_req, scl_hold, irq;
	logic                     auto_ack, ack_send;
	bus_ctl_pkg::bus_event_t  evt;
	bus_ctl_pkg::line_sense_t line;
	int                       bad_count = 0;
	int                       n_tests = 0;
	// Ordinary event cases; each row builds on the state left by the last
	row_t rows [11] = '{
		'{8'h00, 14'h0020, 8'h09}, '{8'h02, 14'h0010, 8'h02}, '{8'h00, 14'h0048, 8'h03},
		'{8'h02, 14'h000C, 8'h00}, '{8'h00, 14'h0200, 8'h21}, '{8'h00, 14'h0180, 8'h11},
		'{8'h00, 14'h0003, 8'h40}, '{8'h00, 14'h0800, 8'h00}, '{8'h01, 14'h0000, 8'h01},
		'{8'h20, 14'h0000, 8'hE1}, '{8'h10, 14'h1000, 8'h40}};

	bus_control_block bus_control_block_i (.i_clock(i_clock), .i_reset(i_reset),
		.i_addr(addr), .i_page(page), .i_wdata(wdata), .i_write(write), .i_read(read),
		.i_bit_write(bit_write), .i_bit_index(bit_index), .i_bit_value(bit_value),
		.i_auto_ack_enable(auto_ack), .i_evt(evt), .i_line(line), .o_rdata(rdata),
		.o_master(master), .o_transmit(transmit), .o_start_request(start_req),
		.o_stop_request(stop_req), .o_ack_send(ack_send), .o_scl_hold(scl_hold), .o_irq(irq));

	bus_engine_model bus_engine_model_i (.i_clock(i_clock), .i_reset(i_reset),
		.i_start_request(start_req), .i_scl_hold(scl_hold), .i_slow(slow),
		.i_conflict(conflict), .i_fire(fire), .o_evt(evt), .o_line(line));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] v);
		@(posedge i_clock);
		addr <= a;
		page <= p;
		wdata <= v;
		write <= 1'b1;
		@(posedge i_clock);
		write <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] v);
		@(posedge i_clock);
		addr <= a;
		page <= p;
		read <= 1'b1;
		@(posedge i_clock);
		read <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic bitw(input logic [2:0] i, input logic v);
		@(posedge i_clock);
		addr <= 8'hC0;
		page <= 4'h0;
		bit_index <= i;
		bit_value <= v;
		bit_write <= 1'b1;
		@(posedge i_clock);
		bit_write <= 1'b0;
	endtask
	task automatic pulse(input logic [13:0] e);
		@(posedge i_clock);
		fire <= e;
		@(posedge i_clock);
		fire <= 14'h0000;
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Bounded wait; a start that never comes ends the run
	task automatic wait_master();
		int k;
		k = 0;
		while (master !== 1'b1) begin
			@(posedge i_clock);
			k++;
			if (k > 20) begin
				bad_count++;
				$display("mismatch at %0t: no start", $time);
				complete_run();
			end
		end
	endtask

	// ----------------------------------------
	// Clock and sequence
	// ----------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	initial begin
		i_reset = 1'b1;
		{write, read, bit_write, bit_value, slow, conflict, auto_ack} = 7'h00;
		{addr, wdata, page, bit_index, fire} = '0;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(8'hC0, 4'h0, d);
		check(d, 8'h00);
		check({7'h00, irq}, 8'h00);
		$display("reset test done");
		foreach (rows[n]) begin
			wr(8'hC0, 4'h0, rows[n].pre);
			if (rows[n].ev != 14'h0000) begin
				pulse(rows[n].ev);
			end
			if (rows[n].pre[5]) begin
				wait_master();
			end
			repeat (4) @(posedge i_clock);
			rd(8'hC0, 4'h0, d);
			check(d, rows[n].exp);
			check({6'h00, master, transmit}, {6'h00, rows[n].exp[7:6]});
			check({6'h00, irq, scl_hold}, {6'h00, {2{rows[n].exp[0]}}});
			$display("row %0d done", n);
		end
		// Unmapped address and wrong page are both ignored
		wr(8'hC1, 4'h0, 8'hFF);
		wr(8'hC0, 4'h1, 8'hFF);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h40);
		rd(8'hC1, 4'h0, d);
		check(d, 8'h00);
		$display("unmapped test done");
		// Sensed low while driving a one: loss also drops direction
		@(posedge i_clock);
		conflict <= 1'b1;
		@(posedge i_clock);
		conflict <= 1'b0;
		repeat (6) @(posedge i_clock);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h05);
		wr(8'hC0, 4'h0, 8'h00);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h00);
		$display("arbitration test done");
		// Single-bit access; read-only bits stay put
		bitw(3'h0, 1'b1);
		bitw(3'h7, 1'b1);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h01);
		bitw(3'h0, 1'b0);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h00);
		$display("bit access test done");
		// Slow far side still produces the start
		@(posedge i_clock);
		slow <= 1'b1;
		wr(8'hC0, 4'h0, 8'h20);
		wait_master();
		repeat (2) @(posedge i_clock);
		rd(8'hC0, 4'h0, d);
		check(d, 8'hE1);
		$display("slow start test done");
		// Second reset in mid-run
		@(posedge i_clock);
		i_reset <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(8'hC0, 4'h0, d);
		check(d, 8'h00);
		check({6'h00, irq, master}, 8'h00);
		$display("second reset test done");
		// Ack choice: a written ack holds only until the service ends
		bitw(3'h1, 1'b1);
		pulse(14'h0020);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h0B);
		check({7'h00, ack_send}, 8'h01);
		bitw(3'h0, 1'b0);
		rd(8'hC0, 4'h0, d);
		check({7'h00, ack_send}, 8'h00);
		// Hardware ack: no request, and the ack bit goes out as it stands
		@(posedge i_clock);
		auto_ack <= 1'b1;
		pulse(14'h0030);
		rd(8'hC0, 4'h0, d);
		check(d, 8'h03);
		check({7'h00, ack_send}, 8'h01);
		$display("ack test done");
		// Halt written as controller waits out the stall, then both requests rise
		wr(8'hC0, 4'h0, 8'h22);
		wait_master();
		bitw(3'h4, 1'b1);
		rd(8'hC0, 4'h0, d);
		check(d, 8'hF3);
		check({6'h00, start_req, stop_req}, 8'h00);
		bitw(3'h0, 1'b0);
		rd(8'hC0, 4'h0, d);
		check({6'h00, start_req, stop_req}, 8'h03);
		pulse(14'h1000);
		repeat (6) @(posedge i_clock);
		rd(8'hC0, 4'h0, d);
		check(d, 8'hE3);
		check({6'h00, start_req, stop_req}, 8'h00);
		$display("stop and start test done");
		complete_run();
	end
endmodule
`default_nettype wire
